//--- src/mhrc_consts.svh
// Constants for the micro hold and repeat control block
// ****************************************************
// ****************************************************
`ifndef MHRC_CONSTS_SVH
`define MHRC_CONSTS_SVH
`define MHRC_OFF_CTRL 4'h0
`define MHRC_OFF_STAT 4'h4
`define MHRC_OFF_IR 4'h8
`define MHRC_CTRL_RUN 0
`define MHRC_CTRL_TAPE 1
`define MHRC_CTRL_RST 2'h0
`define MHRC_OP_PADX 8'h7d
`define MHRC_OP_LIT 8'h9c
`define MHRC_OP_RMOV1 8'h1c
`define MHRC_OP_RMOV2 8'h2c
`define MHRC_OP_EXT 8'h3f
`define MHRC_SRC_ASM 4'h3
`define MHRC_ASM_BITS 16
`endif

//--- src/mhrc_pkg.sv
// Types shared by the micro hold and repeat control block
package mhrc_pkg;
  // Sequencer phases, one-hot
  typedef enum logic [4:0] {
    MHRC_S0 = 5'b00001,
    MHRC_S1 = 5'b00010,
    MHRC_S2 = 5'b00100,
    MHRC_S3 = 5'b01000,
    MHRC_S4 = 5'b10000
  } mhrc_phase_t;
  // Drive onto the low half of the main exchange
  typedef struct packed {
    logic en;
    logic [15:0] data;
  } mhrc_xchg_t;
endpackage

//--- src/mhrc_top.sv
// Micro hold, repeat and latch-read control with an Avalon-MM register slave
`timescale 1ns/1ps
`include "mhrc_consts.svh"
module mhrc_top #(
  parameter int ASM_BITS = `MHRC_ASM_BITS
) (
  input wire logic CLK_I, // Processor clock, 40 MHz
  input wire logic RST_I, // General processor clear
  input wire logic [3:0] AVS_ADDRESS_I, // Byte address
  input wire logic AVS_READ_I, // Read strobe
  input wire logic AVS_WRITE_I, // Write strobe
  input wire logic [31:0] AVS_WRITEDATA_I, // Write data
  output logic [31:0] AVS_READDATA_O, // Read data
  output logic AVS_WAITREQUEST_O, // Stall
  input wire logic [31:0] FETCH_LATCH_I, // Fetched-micro latch contents
  input wire logic BRANCH_I, // Current op branches or skips
  input wire logic REFRESH_DEMAND_I, // Memory refresh demanded
  input wire logic TAPE_STB_I, // Tape bit strobe pin
  input wire logic TAPE_BIT_I, // Tape data pin
  input wire logic ASM_LOAD_I, // Register source fills assembly
  input wire logic [15:0] ASM_DATA_I, // Register source data
  output mhrc_pkg::mhrc_xchg_t XCHG_O, // Low exchange drive
  output logic [15:0] MICRO_BUS_O, // Micro operator bus
  output logic FINISH_PULSE_O, // Finish pulse
  output logic REFRESH_GRANT_O, // Refresh granted
  output logic LATCH_READ_ENABLE_O, // Fetch latch read
  output logic LATCH_HALF_SELECT_O, // Latch half in use
  output logic MICRO_FETCH_O, // Fetch of next micro
  output mhrc_pkg::mhrc_phase_t PHASE_O // Sequencer phase
);
  import mhrc_pkg::*;

  // ****************************************************
  // Checks and declarations
  // ****************************************************
  if (ASM_BITS != 16) begin : g_asm_bits_chk
    $error("mhrc_top: ASM_BITS must be 16");
  end
  // All checks run on the processor clock and stop during a general clear
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  logic [1:0] ctrl;
  logic running;
  logic tape_micro_mode;
  mhrc_phase_t phase;
  logic [15:0] ir;
  logic repeat_flag;
  logic hold;
  logic expose_signal;
  logic finish_pulse;
  logic [15:0] asm_reg;
  logic [4:0] asm_cnt;
  logic assembly_full;
  logic assembly_not_full_wait;
  logic held_full_finish;
  logic sequential_fetch_ok;
  logic refresh_grant;
  logic latch_read_enable;
  logic latch_half_select;
  logic [15:0] latch_half;
  logic is_padx;
  logic is_lit;
  logic is_ext;
  logic assembly_source_op;
  logic wait_term;
  logic consume;
  logic tape_load;
  logic [2:0] stb_sync;
  logic [2:0] bit_sync;
  logic stb_seen;
  logic ack;

  // Opcode match shared by several decodes
  function automatic logic op_is(input logic [15:0] v, input logic [7:0] code);
    op_is = (v[7:0] == code);
  endfunction

  // ****************************************************
  // Decode
  // ****************************************************
  assign running = ctrl[`MHRC_CTRL_RUN];
  assign tape_micro_mode = ctrl[`MHRC_CTRL_TAPE];
  // Repeat plus full overrides hold so the waiting op runs at once
  assign expose_signal = !hold || (repeat_flag && assembly_full);
  assign is_padx = expose_signal && op_is(ir, `MHRC_OP_PADX);
  assign is_lit = expose_signal && op_is(ir, `MHRC_OP_LIT);
  assign is_ext = expose_signal && op_is(ir, `MHRC_OP_EXT);
  assign assembly_source_op = expose_signal && !tape_micro_mode
    && (op_is(ir, `MHRC_OP_RMOV1) || op_is(ir, `MHRC_OP_RMOV2))
    && (ir[11:8] == `MHRC_SRC_ASM);
  // Wait term: tape literal-move or run-mode assembly source, first clock only
  assign wait_term = running && (phase == MHRC_S0) && !repeat_flag
    && ((tape_micro_mode && is_lit) || assembly_source_op);

  // Finish decode per op length
  always_comb begin
    finish_pulse = 1'b0;
    if (running) begin
      if (wait_term) begin
        finish_pulse = 1'b0;
      end else if (is_padx) begin
        finish_pulse = (phase == MHRC_S4) && !repeat_flag;
      end else if (is_lit || is_ext) begin
        finish_pulse = (phase == MHRC_S3);
      end else begin
        finish_pulse = (phase == MHRC_S1);
      end
    end
  end

  // ****************************************************
  // Latch read control
  // ****************************************************
  assign assembly_not_full_wait = !(repeat_flag && assembly_full);
  assign held_full_finish = expose_signal && assembly_not_full_wait && finish_pulse;
  // Refresh also kills sequential fetch so zeros load instead
  assign refresh_grant = REFRESH_DEMAND_I && finish_pulse;
  assign sequential_fetch_ok = !BRANCH_I && !refresh_grant;
  assign latch_half = latch_half_select ? FETCH_LATCH_I[31:16] : FETCH_LATCH_I[15:0];
  // Literal read happens at phases two and three of a run-mode literal-move
  always_comb begin
    latch_read_enable = 1'b0;
    if (running && !tape_micro_mode) begin
      if (is_lit && (phase == MHRC_S2 || phase == MHRC_S3)) begin
        latch_read_enable = 1'b1;
      end else if (held_full_finish && sequential_fetch_ok && !is_lit
          && !assembly_source_op) begin
        latch_read_enable = 1'b1;
      end
    end
  end
  assign consume = finish_pulse && (is_lit || (assembly_source_op && repeat_flag));
  assign tape_load = running && tape_micro_mode && hold && !repeat_flag
    && assembly_full && finish_pulse;

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      phase <= MHRC_S0;
    end else if (!running || finish_pulse) begin
      phase <= MHRC_S0;
    end else begin
      unique case (phase)
        MHRC_S0: phase <= MHRC_S1;
        MHRC_S1: phase <= MHRC_S2;
        MHRC_S2: phase <= MHRC_S3;
        MHRC_S3: phase <= MHRC_S4;
        MHRC_S4: phase <= MHRC_S0;
        default: phase <= MHRC_S0;
      endcase
    end
  end

  // ****************************************************
  // Repeat and hold flags
  // ****************************************************
  // Pad-exchange toggles repeat at each phase zero: set first, clear second
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      repeat_flag <= 1'b0;
    end else if (is_padx && running && phase == MHRC_S0) begin
      repeat_flag <= !repeat_flag;
    end else if (wait_term) begin
      repeat_flag <= 1'b1;
    end else if (consume) begin
      repeat_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      hold <= 1'b0;
    end else if (wait_term) begin
      hold <= 1'b1;
    end else if (tape_load) begin
      hold <= 1'b0;
    end else if (finish_pulse && expose_signal && tape_micro_mode) begin
      hold <= 1'b1;
    end else if (consume) begin
      hold <= 1'b0;
    end
  end

  // ****************************************************
  // Instruction register
  // ****************************************************
  // Software may preload it; a held op is left in place while no-ops run
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ir <= 16'h0000;
    end else if (AVS_WRITE_I && ack && AVS_ADDRESS_I == `MHRC_OFF_IR) begin
      ir <= AVS_WRITEDATA_I[15:0];
    end else if (tape_load) begin
      ir <= asm_reg;
    end else if (finish_pulse && expose_signal) begin
      if (consume) begin
        ir <= 16'h0000;
      end else if (latch_read_enable) begin
        ir <= latch_half;
      end else begin
        ir <= 16'h0000;
      end
    end
  end

  // Half select alternates across the two micros of one latch word
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      latch_half_select <= 1'b0;
    end else if (latch_read_enable && !is_lit) begin
      latch_half_select <= !latch_half_select;
    end
  end

  // ****************************************************
  // Assembly register and tape pin synchronisers
  // ****************************************************
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stb_sync <= 3'h0;
      bit_sync <= 3'h0;
    end else begin
      stb_sync <= {stb_sync[1:0], TAPE_STB_I};
      bit_sync <= {bit_sync[1:0], TAPE_BIT_I};
    end
  end
  // Second and third stage agree before a strobe counts
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stb_seen <= 1'b0;
    end else if (stb_sync[1] == stb_sync[2]) begin
      stb_seen <= stb_sync[2];
    end
  end

  // A new fill beats a consume in the same cycle so no word is lost
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      asm_reg <= 16'h0000;
      asm_cnt <= 5'h00;
    end else if (ASM_LOAD_I && !tape_micro_mode) begin
      asm_reg <= ASM_DATA_I;
      asm_cnt <= 5'(ASM_BITS);
    end else if (tape_micro_mode && stb_sync[2] && stb_sync[1] && !stb_seen
        && !assembly_full && bit_sync[1] == bit_sync[2]) begin
      asm_reg <= {asm_reg[14:0], bit_sync[2]};
      asm_cnt <= asm_cnt + 5'h01;
    end else if (consume || tape_load) begin
      asm_cnt <= 5'h00;
    end
  end
  assign assembly_full = (asm_cnt == 5'(ASM_BITS));

  // ****************************************************
  // Output drives
  // ****************************************************
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      MICRO_BUS_O <= 16'h0000;
      XCHG_O <= '0;
    end else begin
      MICRO_BUS_O <= (expose_signal && running) ? ir : 16'h0000;
      XCHG_O.en <= is_lit && running && (phase == MHRC_S2 || phase == MHRC_S3);
      XCHG_O.data <= tape_micro_mode ? asm_reg : latch_half;
    end
  end
  assign FINISH_PULSE_O = finish_pulse;
  assign REFRESH_GRANT_O = refresh_grant;
  assign LATCH_READ_ENABLE_O = latch_read_enable;
  assign LATCH_HALF_SELECT_O = latch_half_select;
  assign MICRO_FETCH_O = latch_read_enable && !is_lit;
  assign PHASE_O = phase;

  // ****************************************************
  // Avalon-MM slave, one wait cycle per access
  // ****************************************************
  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack <= 1'b0;
    end else begin
      ack <= (AVS_READ_I || AVS_WRITE_I) && !ack;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl <= `MHRC_CTRL_RST;
    end else if (AVS_WRITE_I && ack && AVS_ADDRESS_I == `MHRC_OFF_CTRL) begin
      ctrl <= AVS_WRITEDATA_I[1:0];
    end
  end

  // Unmapped addresses read zero
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      AVS_READDATA_O <= 32'h00000000;
    end else if (AVS_READ_I && !ack) begin
      unique case (AVS_ADDRESS_I)
        `MHRC_OFF_CTRL: AVS_READDATA_O <= {30'h0, ctrl};
        `MHRC_OFF_STAT: AVS_READDATA_O <= {18'h0, asm_cnt, assembly_full,
          expose_signal, hold, repeat_flag, phase};
        `MHRC_OFF_IR: AVS_READDATA_O <= {16'h0, ir};
        default: AVS_READDATA_O <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  property p_padx_set;
    (is_padx && running && phase == MHRC_S0 && !repeat_flag) |=> repeat_flag;
  endproperty
  a_padx_set: assert property (p_padx_set) else $error("repeat not set");
  property p_padx_len;
    (is_padx && running && phase == MHRC_S0 && !repeat_flag && !REFRESH_DEMAND_I)
      |-> !finish_pulse [*5] ##1 !finish_pulse [*4] ##1 finish_pulse;
  endproperty
  a_padx_len: assert property (p_padx_len) else $error("pad op not ten clocks");
  property p_padx_clr;
    (is_padx && running && phase == MHRC_S0 && repeat_flag) |=> !repeat_flag;
  endproperty
  a_padx_clr: assert property (p_padx_clr) else $error("repeat not cleared");
  property p_wait;
    wait_term |=> (repeat_flag && hold && phase == MHRC_S1);
  endproperty
  a_wait: assert property (p_wait) else $error("wait term ignored");
  property p_expose;
    (repeat_flag && assembly_full && running) |=> MICRO_BUS_O == $past(ir);
  endproperty
  a_expose: assert property (p_expose) else $error("held op not exposed");
  property p_noop_fin;
    (running && !expose_signal && phase == MHRC_S1) |-> finish_pulse;
  endproperty
  a_noop_fin: assert property (p_noop_fin) else $error("no-op without finish");
  property p_full;
    $rose(assembly_full) |-> ($past(asm_cnt) == 5'd15 || $past(ASM_LOAD_I));
  endproperty
  a_full: assert property (p_full) else $error("full too early");
  property p_tape_block;
    tape_micro_mode |-> !latch_read_enable;
  endproperty
  a_tape_block: assert property (p_tape_block) else $error("latch read in tape");
  property p_refresh;
    refresh_grant |-> (!latch_read_enable && !$past(RST_I));
  endproperty
  a_refresh: assert property (p_refresh) else $error("read during refresh");
  property p_lit_clear;
    (finish_pulse && is_lit && !tape_load) |=> ir == 16'h0000;
  endproperty
  a_lit_clear: assert property (p_lit_clear) else $error("ir not cleared");
  property p_xchg;
    XCHG_O.en |-> $past(is_lit) && ($past(phase) == MHRC_S2 || $past(phase) == MHRC_S3);
  endproperty
  a_xchg: assert property (p_xchg) else $error("exchange drive off phase");
  property p_hold_keep;
    (hold && !expose_signal && !tape_load && !(AVS_WRITE_I && ack)) |=> $stable(ir);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("held op lost");

  c_padx: cover property (@(posedge CLK_I) finish_pulse && is_padx);
  c_tape_lit: cover property (@(posedge CLK_I) finish_pulse && is_lit && tape_micro_mode);
  c_refresh: cover property (@(posedge CLK_I) refresh_grant && is_ext);
  c_load: cover property (@(posedge CLK_I) tape_load);
endmodule

//--- tb/mhrc_far_model.sv
// Far-side model: fetched-micro latch and cassette tape bit source
`timescale 1ns/1ps
module mhrc_far_model (
  input wire logic clk_i, // Processor clock
  input wire logic rst_i, // General clear
  input wire logic fetch_i, // Micro fetch from the block
  input wire logic [31:0] mem_word_i, // Memory word read on a fetch
  input wire logic [15:0] tape_word_i, // Word to send from tape
  input wire logic tape_go_i, // Start sending the tape word
  output logic [31:0] latch_o, // Fetch latch contents
  output logic tape_stb_o, // Tape bit strobe
  output logic tape_bit_o // Tape data
);
  logic [2:0] tick;
  logic [4:0] left;
  logic [15:0] sr;
  // Latch only changes on a fetch, as a real memory latch would
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_o <= 32'h0;
    end else if (fetch_i) begin
      latch_o <= mem_word_i;
    end
  end
  // Bit first, strobe high two clocks, then data line no longer held
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick <= 3'h0;
      left <= 5'h0;
      sr <= 16'h0;
      tape_stb_o <= 1'b0;
      tape_bit_o <= 1'b0;
    end else if (left == 5'h0) begin
      tick <= 3'h0;
      if (tape_go_i) begin
        sr <= tape_word_i;
        left <= 5'h10;
      end
    end else begin
      tick <= tick + 3'h1;
      if (tick == 3'h0) tape_bit_o <= sr[15];
      if (tick == 3'h2) tape_stb_o <= 1'b1;
      if (tick == 3'h4) tape_stb_o <= 1'b0;
      if (tick == 3'h5) begin
        tape_bit_o <= ~tape_bit_o;
        sr <= {sr[14:0], 1'b0};
        left <= left - 5'h1;
        tick <= 3'h0;
      end
    end
  end
endmodule

//--- tb/mhrc_top_tb.sv
// Self-checking bench for the micro hold and repeat control block
`timescale 1ns/1ps
`include "mhrc_consts.svh"
module mhrc_top_tb;
  import mhrc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [31:0] latch;
  logic branch = 1'b0;
  logic demand = 1'b0;
  logic stb;
  logic tbit;
  logic asm_ld = 1'b0;
  logic [15:0] asm_dat = 16'h0;
  mhrc_xchg_t xchg;
  mhrc_phase_t phase;
  logic [15:0] mbus;
  logic fin;
  logic gnt;
  logic lre;
  logic hsel;
  logic micro_fetch;
  logic [31:0] mem_word = 32'h0;
  logic [15:0] tword = 16'h0;
  logic tgo = 1'b0;
  logic [63:0] hist = 64'h0;
  logic [15:0] xdat;
  logic [15:0] mb_fin;
  logic [31:0] q;
  int n_fin, n_lre, n_gnt, n_xen;
  int err_count = 0;
  int tests_run = 0;

  mhrc_top dut (.CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd_s),
    .AVS_WRITE_I(wr_s), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .FETCH_LATCH_I(latch), .BRANCH_I(branch),
    .REFRESH_DEMAND_I(demand), .TAPE_STB_I(stb), .TAPE_BIT_I(tbit), .ASM_LOAD_I(asm_ld),
    .ASM_DATA_I(asm_dat), .XCHG_O(xchg), .MICRO_BUS_O(mbus), .FINISH_PULSE_O(fin),
    .REFRESH_GRANT_O(gnt), .LATCH_READ_ENABLE_O(lre), .LATCH_HALF_SELECT_O(hsel),
    .MICRO_FETCH_O(micro_fetch), .PHASE_O(phase));
  mhrc_far_model far (.clk_i(clk), .rst_i(rst), .fetch_i(micro_fetch), .mem_word_i(mem_word),
    .tape_word_i(tword), .tape_go_i(tgo), .latch_o(latch), .tape_stb_o(stb),
    .tape_bit_o(tbit));

  // 40 MHz processor clock
  always #12.5 clk = ~clk;

  function automatic logic [2:0] idx(input logic [4:0] p);
    idx = 3'h7;
    for (int i = 0; i < 5; i++) if (p[i]) idx = 3'(i);
  endfunction

  // Per-cycle phase and finish history; sampled mid-cycle so values are settled
  always @(negedge clk) begin
    hist <= {hist[59:0], fin === 1'b1, idx(phase)};
    if (fin === 1'b1) begin
      n_fin++;
      mb_fin <= mbus;
    end
    if (lre === 1'b1) n_lre++;
    if (gnt === 1'b1) n_gnt++;
    if (xchg.en === 1'b1) begin
      n_xen++;
      xdat <= xchg.data;
    end
  end

  // ************************************
  // Shared tasks
  // ************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic timeout();
    err_count++;
    $display("FAIL wait expected done seen timeout");
    test_done();
  endtask

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Avalon request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic busy;
    int n;
    adr <= a;
    wdat <= d;
    wr_s <= w;
    rd_s <= ~w;
    busy = 1'b1;
    for (n = 0; n < 20 && busy; n++) begin
      @(posedge clk);
      busy = (wreq !== 1'b0);
      if (!busy) q = rdat;
    end
    if (busy) timeout();
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rst_pulse(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wt(input logic x, input int k);
    int n;
    for (n = 0; n < 800 && (x ? n_xen : n_fin) < k; n++) @(posedge clk);
    if ((x ? n_xen : n_fin) < k) timeout();
  endtask

  // Op loaded while stopped, counts cleared, then started
  task automatic run(input logic [31:0] ctl, input logic [31:0] ir);
    rst_pulse(2);
    bus(1'b1, `MHRC_OFF_IR, ir);
    n_fin = 0;
    n_lre = 0;
    n_gnt = 0;
    n_xen = 0;
    bus(1'b1, `MHRC_OFF_CTRL, ctl);
  endtask

  // ************************************
  // Scenarios
  // ************************************
  task automatic t_reset();
    bus(1'b0, `MHRC_OFF_STAT, 32'h0);
    chk("status", q, 32'h81);
    bus(1'b1, `MHRC_OFF_STAT, 32'hffff);
    bus(1'b0, `MHRC_OFF_STAT, 32'h0);
    chk("status_ro", q, 32'h81);
    bus(1'b0, 4'hc, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("done reset");
  endtask

  task automatic t_pad();
    run(32'h1, {24'h0, `MHRC_OP_PADX});
    wt(1'b0, 1);
    chk("pad_seq", hist[39:0], 40'h012340123c);
    bus(1'b0, `MHRC_OFF_STAT, 32'h0);
    chk("pad_repeat", q[5], 1'b0);
    $display("done pad exchange");
  endtask

  task automatic t_rmov(input logic [7:0] op);
    logic [31:0] ir;
    int n;
    ir = {20'h0, `MHRC_SRC_ASM, op};
    run(32'h1, ir);
    wt(1'b0, 3);
    chk("rmov_noops", hist[15:0], 16'h0909);
    chk("rmov_nofetch", n_lre, 0);
    chk("rmov_hidden", mbus, 16'h0);
    bus(1'b0, `MHRC_OFF_STAT, 32'h0);
    chk("rmov_flags", q[8:5], 4'b0011);
    asm_dat <= 16'hbeef;
    asm_ld <= 1'b1;
    @(posedge clk);
    asm_ld <= 1'b0;
    for (n = 0; n < 20 && mbus !== ir[15:0]; n++) @(negedge clk);
    chk("rmov_exposed", mbus, ir[15:0]);
    @(posedge clk);
    wt(1'b0, n_fin + 2);
    bus(1'b0, `MHRC_OFF_STAT, 32'h0);
    chk("rmov_done", q[7:5], 3'b100);
    $display("done register move");
  endtask

  task automatic t_tape();
    run(32'h3, {24'h0, `MHRC_OP_LIT});
    wt(1'b0, 2);
    bus(1'b0, `MHRC_OFF_STAT, 32'h0);
    chk("tape_flags", q[8:5], 4'b0011);
    tword <= 16'h5a3c;
    tgo <= 1'b1;
    @(posedge clk);
    tgo <= 1'b0;
    wt(1'b1, 2);
    chk("lit_seq", hist[19:0], 20'h012b0);
    chk("lit_xchg", xdat, 16'h5a3c);
    wt(1'b0, n_fin + 2);
    chk("lit_xcnt", n_xen, 2);
    chk("tape_noread", n_lre, 0);
    bus(1'b0, `MHRC_OFF_STAT, 32'h0);
    chk("tape_rehold", q[7:5], 3'b010);
    $display("done tape literal");
  endtask

  task automatic t_fetch();
    run(32'h1, 32'h0);
    wt(1'b0, 4);
    chk("short_seq", hist[15:0], 16'h0909);
    chk("plain_read", n_lre, n_fin);
    @(negedge clk);
    chk("half_sel", hsel, n_lre[0]);
    @(posedge clk);
    branch <= 1'b1;
    n_fin = 0;
    n_lre = 0;
    wt(1'b0, 3);
    chk("branch_block", n_lre, 0);
    branch <= 1'b0;
    demand <= 1'b1;
    n_fin = 0;
    n_gnt = 0;
    wt(1'b0, 3);
    chk("refresh_block", n_lre, 0);
    chk("refresh_grant", n_gnt, 3);
    run(32'h1, {24'h0, `MHRC_OP_EXT});
    wt(1'b0, 1);
    chk("ext_seq", hist[15:0], 16'h012b);
    chk("ext_grant", n_gnt, 1);
    chk("ext_kept", mb_fin, 16'h003f);
    demand <= 1'b0;
    $display("done fetch and refresh");
  endtask

  // Run-mode literal: op in the high half, literal in the low half of one latch word
  task automatic t_lit_run();
    mem_word <= {8'h0, `MHRC_OP_LIT, 16'h4b2d};
    run(32'h1, 32'h0);
    wt(1'b0, 2);
    wt(1'b1, 2);
    chk("run_lit_seq", hist[19:0], 20'h012b0);
    chk("run_lit_xchg", xdat, 16'h4b2d);
    chk("run_lit_reads", n_lre, 4);
    mem_word <= 32'h0;
    $display("done run literal");
  endtask

  // Clear in the middle of a held op leaves no repeat or hold behind
  task automatic t_clear();
    run(32'h1, {20'h0, `MHRC_SRC_ASM, `MHRC_OP_RMOV1});
    wt(1'b0, 2);
    rst_pulse(2);
    bus(1'b0, `MHRC_OFF_STAT, 32'h0);
    chk("clear_flags", q, 32'h81);
    $display("done mid-run clear");
  endtask

  initial begin
    rst_pulse(20);
    t_reset();
    t_pad();
    t_rmov(`MHRC_OP_RMOV1);
    t_rmov(`MHRC_OP_RMOV2);
    t_tape();
    t_lit_run();
    t_fetch();
    t_clear();
    test_done();
  end
endmodule
